// ===== core/mrc_defs.svh
// Offsets, field positions, reset values and timing counts of the mode and reset control block
`ifndef MRC_DEFS_SVH
`define MRC_DEFS_SVH

// Register byte addresses on the APB
`define MRC_WDT_CSR_ADDR    16'hffbc
`define MRC_RST_CSR_ADDR    16'hffbe
`define MRC_SYS_CTRL_ADDR   16'hffc0
`define MRC_MODE_STAT_ADDR  16'hffc4
`define MRC_CPU_STAT_ADDR   16'hffc8

// Reset values
`define MRC_WDT_CSR_RST     16'h0018
`define MRC_RST_CSR_RST     16'h001f
`define MRC_SYS_CTRL_RST    8'hc1

// Field positions
`define MRC_SYS_ONCHIP_RAM_ENABLE_BIT    0
`define MRC_SYS_EXTERNAL_BUS_ENABLE_BIT    1
`define MRC_RST_WATCHDOG_OVERFLOW_INIT_ENABLE_BIT    6
`define MRC_RST_WOVF_BIT    7
`define MRC_FLW_FLASH_COMMAND_BLOCK_BIT_BIT   0
`define MRC_FLW_CMDEN_BIT   1

// Watchdog reset length in system clocks
`define MRC_WDT_RST_CLKS    10'd518

`endif

// ===== core/mrc_pkg.sv
// Types of the mode and reset control block
`default_nettype none

package mrc_pkg;

  // Operating modes decoded from the straps
  typedef enum logic [2:0] {
    MRC_MODE_BAD = 3'h0,
    MRC_MODE_1   = 3'h1,
    MRC_MODE_2   = 3'h2,
    MRC_MODE_3   = 3'h3,
    MRC_MODE_4   = 3'h4,
    MRC_MODE_5   = 3'h5,
    MRC_MODE_6   = 3'h6,
    MRC_MODE_7   = 3'h7
  } mrc_mode_t;

  // Reset sequencer, Gray coded along the path
  typedef enum logic [1:0] {
    MRC_ST_HOLD  = 2'b00,
    MRC_ST_VECT  = 2'b01,
    MRC_ST_RUN   = 2'b11,
    MRC_ST_WDRST = 2'b10
  } mrc_state_t;

  // Default function of each port group
  typedef enum logic [1:0] {
    MRC_PF_GPIO = 2'h0,
    MRC_PF_ADDR = 2'h1,
    MRC_PF_DATA = 2'h2,
    MRC_PF_CTRL = 2'h3
  } mrc_pfunc_t;

  // Memory and bus configuration seen by the rest of the chip
  typedef struct packed {
    logic       rom_enable;
    logic       ram_enable;
    logic       ext_bus_enable;
    logic       bus_16bit;
    logic       flash_boot;
    logic       flash_user_boot;
    logic       user_program;
    mrc_pfunc_t port_a;
    mrc_pfunc_t port_b;
    mrc_pfunc_t port_c;
    mrc_pfunc_t port_d;
    mrc_pfunc_t port_e;
    mrc_pfunc_t port_fh;
  } mrc_cfg_t;

  // CPU reset handoff
  typedef struct packed {
    logic cpu_reset;
    logic vector_fetch;
    logic trace_clear;
    logic imask_set;
  } mrc_cpu_t;

  // Whole module state
  typedef struct packed {
    logic [2:0]  rst_sync;
    logic [2:0]  wov_sync;
    mrc_state_t  state;
    logic [9:0]  wd_cnt;
    mrc_mode_t   mode;
    logic [15:0] wdt_csr;
    logic [15:0] rst_csr;
    logic [7:0]  sys_ctrl;
    logic        last_wdt;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    mrc_cfg_t    cfg;
    mrc_cpu_t    cpu;
  } mrc_st_t;

endpackage : mrc_pkg

`default_nettype wire

// ===== core/mrc_top.sv
// Mode decode, reset merge and reset cause logic with APB registers
// Notes on behaviour
// - RAM enable bit resets to 1, re-initialised on reset release.
// - Modes 1, 2: ROM off, ports A-C address, D data, E data when 16-bit, F-H control.
// - Mode 1 starts 16-bit, drops to 8-bit only if all areas 8-bit.
// - Modes 2, 4 start 8-bit; any 16-bit area gives 16-bit, E upper data.
// - Mode 3 is flash boot, otherwise like mode 7.
// - Mode 5 is flash user boot, otherwise like mode 7.
// - Mode 4: ROM on, ports A-C start as inputs, port D data.
// - Modes 4, 7: user program mode on block bit 0 or command enable 1.
// - Mode 7 starts single-chip, ROM on, every port general I/O.
// - Mode 7 with external bus enable set: expanded, all areas 16-bit.
// - Port groups take mode defaults; modes 3, 5, 7 start A-E as I/O.
// - Two reset sources only: pin low or watchdog overflow.
// - Reset handling fetches vector, clears trace, sets interrupt masks.
// - Reset handling starts the cycle after flops two and three both read the released pin high.
// - Reset cause register set to 1f only by the pin reset.
// - Watchdog and reset cause registers written as 16-bit accesses.
// - Watchdog overflow with enable bit gives a 518-clock reset.
// - Reset cause register shows pin or watchdog as last source.
// - Straps 001..111 select modes 1-5 and 7; held constant.
// - External bus enable forced 1 in modes 1, 2, 4; writable otherwise.
`timescale 1ns/10ps
`default_nettype none
`include "mrc_defs.svh"

module mrc_top
  import mrc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        chip_init_pin_n,
  input  wire logic        watchdog_overflow,
  input  wire logic [2:0]  mode_select_pins,
  input  wire logic        all_areas_8bit,
  input  wire logic        any_area_16bit,
  input  wire logic [7:0]  flash_control_word1,
  output mrc_cfg_t         cfg,
  output mrc_cpu_t         cpu
);

  mrc_st_t s_reg;
  mrc_st_t s_next;

  // Default port functions for a mode
  function automatic mrc_cfg_t mode_cfg(input mrc_mode_t m, input logic external_bus_enable,
                                        input logic ram, input logic b16);
    mrc_cfg_t c;
    c = '0;
    c.ram_enable = ram;
    c.ext_bus_enable = external_bus_enable;
    c.bus_16bit = b16;
    case (m)
      MRC_MODE_1, MRC_MODE_2: begin
        c.port_a = MRC_PF_ADDR;
        c.port_b = MRC_PF_ADDR;
        c.port_c = MRC_PF_ADDR;
        c.port_d = MRC_PF_DATA;
        c.port_e = b16 ? MRC_PF_DATA : MRC_PF_GPIO;
        c.port_fh = MRC_PF_CTRL;
      end
      MRC_MODE_4: begin
        c.rom_enable = 1'b1;
        c.port_d = MRC_PF_DATA;
        c.port_e = b16 ? MRC_PF_DATA : MRC_PF_GPIO;
        c.port_fh = MRC_PF_CTRL;
      end
      MRC_MODE_3, MRC_MODE_5, MRC_MODE_7: begin
        c.rom_enable = 1'b1;
        c.flash_boot = (m == MRC_MODE_3);
        c.flash_user_boot = (m == MRC_MODE_5);
        c.port_d = external_bus_enable ? MRC_PF_DATA : MRC_PF_GPIO;
        c.port_e = (external_bus_enable && b16) ? MRC_PF_DATA : MRC_PF_GPIO;
        c.port_fh = external_bus_enable ? MRC_PF_CTRL : MRC_PF_GPIO;
      end
      default: begin
        c.rom_enable = 1'b1;
      end
    endcase
    return c;
  endfunction

  // Modes where the external bus enable is fixed at 1
  function automatic logic external_bus_enable_fixed(input mrc_mode_t m);
    return (m == MRC_MODE_1) || (m == MRC_MODE_2) || (m == MRC_MODE_4);
  endfunction

  logic rst_pin_low;
  logic wov_rise;
  logic ram_bit;
  logic external_bus_enable_bit;
  logic b16;
  logic acc;
  logic wr16;

  // Filtered, synchronised inputs
  always_comb begin
    // Pin level counts once flops two and three agree, else held
    rst_pin_low = (s_reg.rst_sync[1] == s_reg.rst_sync[2]) ? ~s_reg.rst_sync[2] :
                  (s_reg.state == MRC_ST_HOLD);
    wov_rise = s_reg.wov_sync[1] & s_reg.wov_sync[2] & 1'b1;
    ram_bit = s_reg.sys_ctrl[`MRC_SYS_ONCHIP_RAM_ENABLE_BIT];
    external_bus_enable_bit = s_reg.sys_ctrl[`MRC_SYS_EXTERNAL_BUS_ENABLE_BIT];
    acc = psel & penable & ~s_reg.pready;
    wr16 = &pstrb[1:0];
  end

  // Bus width follows mode start width and area settings
  always_comb begin
    if (s_reg.mode == MRC_MODE_1) begin
      b16 = ~all_areas_8bit;
    end else if (s_reg.mode == MRC_MODE_2 || s_reg.mode == MRC_MODE_4) begin
      b16 = any_area_16bit;
    // expanded mode 7 family starts 16-bit
    end else begin
      b16 = external_bus_enable_bit & ~all_areas_8bit;
    end
  end

  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.rst_sync = {s_reg.rst_sync[1:0], chip_init_pin_n};
    s_next.wov_sync = {s_reg.wov_sync[1:0], watchdog_overflow};
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;

    case (s_reg.state)
      MRC_ST_HOLD: begin
        // straps sampled while held in reset
        s_next.mode = mrc_mode_t'(mode_select_pins);
        s_next.sys_ctrl = `MRC_SYS_CTRL_RST;
        // expansion forced in modes 1, 2, 4
        s_next.sys_ctrl[`MRC_SYS_EXTERNAL_BUS_ENABLE_BIT] = external_bus_enable_fixed(mrc_mode_t'(mode_select_pins));
        s_next.wdt_csr = `MRC_WDT_CSR_RST;
        if (!s_reg.last_wdt) begin
          s_next.rst_csr = `MRC_RST_CSR_RST;
        end
        if (!rst_pin_low) begin
          s_next.state = MRC_ST_VECT;
        end
      end
      MRC_ST_VECT: begin
        s_next.state = MRC_ST_RUN;
      end
      MRC_ST_RUN: begin
        if (wov_rise && s_reg.rst_csr[`MRC_RST_WATCHDOG_OVERFLOW_INIT_ENABLE_BIT]) begin
          s_next.state = MRC_ST_WDRST;
          s_next.wd_cnt = `MRC_WDT_RST_CLKS - 10'd1;
          s_next.last_wdt = 1'b1;
        end
      end
      MRC_ST_WDRST: begin
        s_next.wd_cnt = s_reg.wd_cnt - 10'd1;
        if (s_reg.wd_cnt == 10'd0) begin
          s_next.state = MRC_ST_HOLD;
        end
      end
      default: begin
        s_next.state = MRC_ST_HOLD;
      end
    endcase

    if (rst_pin_low) begin
      s_next.state = MRC_ST_HOLD;
      s_next.last_wdt = 1'b0;
    end

    // APB access, answered after one wait state
    if (acc) begin
      s_next.pready = 1'b1;
      s_next.prdata = '0;
      case (paddr)
        `MRC_WDT_CSR_ADDR: begin
          if (pwrite && wr16) begin
            s_next.wdt_csr = pwdata[15:0];
          end
          s_next.prdata = {16'h0000, s_reg.wdt_csr};
        end
        `MRC_RST_CSR_ADDR: begin
          if (pwrite && wr16) begin
            s_next.rst_csr = pwdata[15:0];
          end
          s_next.prdata = {16'h0000, s_reg.rst_csr};
        end
        `MRC_SYS_CTRL_ADDR: begin
          if (pwrite && pstrb[0]) begin
            s_next.sys_ctrl = pwdata[7:0];
            if (external_bus_enable_fixed(s_reg.mode)) begin
              s_next.sys_ctrl[`MRC_SYS_EXTERNAL_BUS_ENABLE_BIT] = 1'b1;
            end
          end
          s_next.prdata = {24'h000000, s_reg.sys_ctrl};
        end
        `MRC_MODE_STAT_ADDR: begin
          s_next.prdata = {29'h00000000, s_reg.mode};
        end
        `MRC_CPU_STAT_ADDR: begin
          s_next.prdata = {29'h00000000, s_reg.last_wdt, s_reg.state};
        end
        default: begin
          s_next.pslverr = 1'b1;
        end
      endcase
    end

    // watchdog flag set wins over a same-cycle write
    if (s_reg.state == MRC_ST_RUN && wov_rise && s_reg.rst_csr[`MRC_RST_WATCHDOG_OVERFLOW_INIT_ENABLE_BIT]) begin
      s_next.rst_csr[`MRC_RST_WOVF_BIT] = 1'b1;
    end

    s_next.cfg = mode_cfg(s_reg.mode, external_bus_enable_bit, ram_bit, b16);
    // flash boot modes follow mode 7 otherwise
    // user program mode in modes 4 and 7
    s_next.cfg.user_program = (s_reg.mode == MRC_MODE_4 || s_reg.mode == MRC_MODE_7) &&
                              (!flash_control_word1[`MRC_FLW_FLASH_COMMAND_BLOCK_BIT_BIT] ||
                               flash_control_word1[`MRC_FLW_CMDEN_BIT]);
    s_next.cpu.cpu_reset = (s_next.state == MRC_ST_HOLD) || (s_next.state == MRC_ST_WDRST);
    s_next.cpu.vector_fetch = (s_next.state == MRC_ST_VECT);
    s_next.cpu.trace_clear = (s_next.state == MRC_ST_VECT);
    s_next.cpu.imask_set = (s_next.state == MRC_ST_VECT);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.rst_sync <= 3'b000;
      s_reg.sys_ctrl <= `MRC_SYS_CTRL_RST;
      s_reg.wdt_csr <= `MRC_WDT_CSR_RST;
      s_reg.rst_csr <= `MRC_RST_CSR_RST;
      s_reg.cpu.cpu_reset <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign cfg = s_reg.cfg;
  assign cpu = s_reg.cpu;

  // cycles spent in watchdog reset, for checking only
  logic [9:0] wd_len_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_len_cnt <= 10'd0;
    end else if (s_reg.state == MRC_ST_WDRST) begin
      wd_len_cnt <= wd_len_cnt + 10'd1;
    end else begin
      wd_len_cnt <= 10'd0;
    end
  end

  sequence wd_start_s;
    s_reg.state == MRC_ST_RUN ##1 s_reg.state == MRC_ST_WDRST;
  endsequence
  wd_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    wd_start_s |-> cpu.cpu_reset)
    else $error("watchdog reset not handed to the CPU");
  wd_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.state == MRC_ST_WDRST) |=>
      ((s_reg.state == MRC_ST_WDRST) && (wd_len_cnt <= 10'd517)) ||
      ((s_reg.state != MRC_ST_WDRST) && ((wd_len_cnt == 10'd518) || $past(rst_pin_low))))
    else $error("watchdog reset not 518 clocks long");

  cause_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.state == MRC_ST_HOLD && s_reg.last_wdt && !acc) |=> $stable(s_reg.rst_csr))
    else $error("watchdog reset changed the cause register");

  external_bus_enable_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.state == MRC_ST_RUN && external_bus_enable_fixed(s_reg.mode)) |-> external_bus_enable_bit)
    else $error("external bus enable not forced in expanded mode");

  release_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.state == MRC_ST_VECT) |-> cpu.vector_fetch && cpu.trace_clear && cpu.imask_set
     && !cpu.cpu_reset)
    else $error("reset handling did not start on release");

  single_chip_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.mode == MRC_MODE_7 && !external_bus_enable_bit) |=> (cfg.port_d == MRC_PF_GPIO) || $changed(external_bus_enable_bit))
    else $error("single-chip mode port not general I/O");

  // address ports and ROM off in mode 1
  addr_ports_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.mode == MRC_MODE_1 && $stable(s_reg.mode)) |=> cfg.port_a == MRC_PF_ADDR && !cfg.rom_enable)
    else $error("mode 1 ports not address bus");

  narrow_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pwrite && paddr == `MRC_RST_CSR_ADDR && !wr16 && s_reg.state == MRC_ST_RUN
     && !wov_rise) |=> $stable(s_reg.rst_csr))
    else $error("narrow write reached the cause register");

  cause_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.state == MRC_ST_RUN && wov_rise && s_reg.rst_csr[`MRC_RST_WATCHDOG_OVERFLOW_INIT_ENABLE_BIT])
    |=> s_reg.rst_csr[`MRC_RST_WOVF_BIT])
    else $error("watchdog flag not set on overflow");

  ram_init_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.state == MRC_ST_VECT) |-> ram_bit)
    else $error("RAM enable not set after reset");

endmodule // mrc_top

`default_nettype wire

// ===== dv/mrc_board.sv
// Board model: reset pin driver and mode strap resistors
`timescale 1ns/10ps
`default_nettype none

module mrc_board (
  input  wire logic       pclk,
  output logic            chip_init_pin_n,
  output logic [2:0]      mode_select_pins
);

  // Pin released and straps at single-chip mode from power-up
  initial begin
    chip_init_pin_n = 1'b1;
    mode_select_pins = 3'h7;
  end

  task automatic pin_reset(input int low_cyc, input logic [2:0] m);
    @(posedge pclk);
    chip_init_pin_n <= 1'b0;
    @(posedge pclk);
    mode_select_pins <= m;
    repeat (low_cyc) @(posedge pclk);
    chip_init_pin_n <= 1'b1;
  endtask

endmodule // mrc_board
`default_nettype wire

// ===== dv/mrc_top_test.sv
// Self-checking bench for mode and reset control
`timescale 1ns/10ps
`default_nettype none
`include "mrc_defs.svh"

module mrc_top_test
  import mrc_pkg::*;
;
  localparam int PIN_LOW = 20; // Scaled-down pin hold time

  typedef struct packed {
    logic [2:0] mode;
    logic       rom;
    logic       ext;
    logic       b16;
    mrc_pfunc_t pa;
    mrc_pfunc_t pd;
    mrc_pfunc_t pe;
    logic       fb;
    logic       fub;
  } mrc_row_t;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        chip_init_pin_n, watchdog_overflow, all_areas_8bit, any_area_16bit;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [2:0]  mode_select_pins;
  logic [7:0]  flash_control_word1;
  mrc_cfg_t    cfg;
  mrc_cpu_t    cpu;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          n;
  mrc_row_t    rows [6] = '{
    '{3'h1, 1'b0, 1'b1, 1'b1, MRC_PF_ADDR, MRC_PF_DATA, MRC_PF_DATA, 1'b0, 1'b0},
    '{3'h2, 1'b0, 1'b1, 1'b0, MRC_PF_ADDR, MRC_PF_DATA, MRC_PF_GPIO, 1'b0, 1'b0},
    '{3'h3, 1'b1, 1'b0, 1'b0, MRC_PF_GPIO, MRC_PF_GPIO, MRC_PF_GPIO, 1'b1, 1'b0},
    '{3'h4, 1'b1, 1'b1, 1'b0, MRC_PF_GPIO, MRC_PF_DATA, MRC_PF_GPIO, 1'b0, 1'b0},
    '{3'h5, 1'b1, 1'b0, 1'b0, MRC_PF_GPIO, MRC_PF_GPIO, MRC_PF_GPIO, 1'b0, 1'b1},
    '{3'h7, 1'b1, 1'b0, 1'b0, MRC_PF_GPIO, MRC_PF_GPIO, MRC_PF_GPIO, 1'b0, 1'b0}};

  mrc_top u_mrc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_init_pin_n(chip_init_pin_n),
    .watchdog_overflow(watchdog_overflow), .mode_select_pins(mode_select_pins),
    .all_areas_8bit(all_areas_8bit), .any_area_16bit(any_area_16bit),
    .flash_control_word1(flash_control_word1), .cfg(cfg), .cpu(cpu));

  mrc_board u_mrc_board (
    .pclk(pclk), .chip_init_pin_n(chip_init_pin_n), .mode_select_pins(mode_select_pins));

  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("Mismatches %0d, comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      error_cnt++;
      $display("Error at %0t: bus wait timed out", $time);
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hf);
    chk(rd, exp);
    chk(err, 1'b0);
  endtask

  // Pin reset, then one vector fetch with flag updates
  task automatic reset_to(input logic [2:0] m);
    n = 0;
    u_mrc_board.pin_reset(PIN_LOW, m);
    repeat (24) begin
      @(posedge pclk);
      if ((cpu.vector_fetch & cpu.trace_clear & cpu.imask_set) === 1'b1) n++;
    end
    chk(n, 1);
    chk(cpu.cpu_reset, 1'b0);
  endtask

  // Overflow pulse, then count cycles held in reset
  task automatic wd_pulse();
    watchdog_overflow <= 1'b1;
    repeat (2) @(posedge pclk);
    watchdog_overflow <= 1'b0;
    n = 0;
    repeat (700) begin
      @(posedge pclk);
      if (cpu.cpu_reset === 1'b1) n++;
    end
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    watchdog_overflow = 1'b0;
    all_areas_8bit = 1'b0;
    any_area_16bit = 1'b0;
    flash_control_word1 = 8'h01;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    reset_to(3'h7);
    rd_chk(`MRC_WDT_CSR_ADDR, 32'h18);
    rd_chk(`MRC_RST_CSR_ADDR, 32'h1f);
    apb(1'b0, 16'hffd0, 32'h0, 4'hf);
    chk(err, 1'b1);
    foreach (rows[k]) begin
      reset_to(rows[k].mode);
      chk(cfg.rom_enable, rows[k].rom);
      chk(cfg.ram_enable, 1'b1);
      chk(cfg.ext_bus_enable, rows[k].ext);
      if (rows[k].ext) chk(cfg.bus_16bit, rows[k].b16);
      chk({cfg.port_a, cfg.port_d, cfg.port_e}, {rows[k].pa, rows[k].pd, rows[k].pe});
      chk({cfg.port_b, cfg.port_c}, {rows[k].pa, rows[k].pa});
      chk(cfg.port_fh, rows[k].ext ? MRC_PF_CTRL : MRC_PF_GPIO);
      chk({cfg.flash_boot, cfg.flash_user_boot}, {rows[k].fb, rows[k].fub});
      rd_chk(`MRC_MODE_STAT_ADDR, rows[k].mode);
      rd_chk(`MRC_SYS_CTRL_ADDR, {6'h30, rows[k].ext, 1'b1});
    end
    // Mode 7: expanded switch, RAM off, user program decode
    apb(1'b1, `MRC_SYS_CTRL_ADDR, 32'hc2, 4'hf);
    repeat (2) @(posedge pclk);
    chk(cfg.ram_enable, 1'b0);
    chk({cfg.ext_bus_enable, cfg.bus_16bit}, 2'b11);
    chk({cfg.port_d, cfg.port_fh}, {MRC_PF_DATA, MRC_PF_CTRL});
    for (int k = 0; k < 4; k++) begin
      flash_control_word1 <= 8'(k);
      repeat (4) @(posedge pclk);
      chk(cfg.user_program, k != 1);
    end
    flash_control_word1 <= 8'h01;
    reset_to(3'h7);
    chk({cfg.ram_enable, cfg.ext_bus_enable}, 2'b10);
    // Mode 1 drops to 8 bits, bus enable stays forced
    reset_to(3'h1);
    all_areas_8bit <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(cfg.bus_16bit, 1'b0);
    apb(1'b1, `MRC_SYS_CTRL_ADDR, 32'h0, 4'hf);
    apb(1'b0, `MRC_SYS_CTRL_ADDR, 32'h0, 4'hf);
    chk(rd[1:0], 2'b10);
    all_areas_8bit <= 1'b0;
    // Mode 2 widens to 16 bits
    reset_to(3'h2);
    any_area_16bit <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({cfg.bus_16bit, cfg.port_e}, {1'b1, MRC_PF_DATA});
    any_area_16bit <= 1'b0;
    // Watchdog reset and cause register
    apb(1'b1, `MRC_RST_CSR_ADDR, 32'h0, 4'h1);
    rd_chk(`MRC_RST_CSR_ADDR, 32'h1f);
    wd_pulse();
    chk(n, 0);
    apb(1'b1, `MRC_RST_CSR_ADDR, 32'h40, 4'h3);
    apb(1'b1, `MRC_WDT_CSR_ADDR, 32'h5a, 4'h3);
    rd_chk(`MRC_WDT_CSR_ADDR, 32'h5a);
    wd_pulse();
    chk(n >= 518 && n <= 530, 1'b1);
    apb(1'b0, `MRC_RST_CSR_ADDR, 32'h0, 4'hf);
    chk(rd[7:6], 2'b11);
    rd_chk(`MRC_WDT_CSR_ADDR, 32'h18);
    rd_chk(`MRC_CPU_STAT_ADDR, {29'h0, 1'b1, MRC_ST_RUN});
    reset_to(3'h7);
    rd_chk(`MRC_RST_CSR_ADDR, 32'h1f);
    complete_run();
  end

endmodule // mrc_top_test
`default_nettype wire
